// ==== sim/oms_master_model.sv ====
// Remote master model: holding-register writes with message pulses
// Assumes the sequencer samples a write strobe on the rising edge of clk
module oms_master_model
  import oms_pkg::*;
(
  input wire logic clk,
  output logic reg_wr,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic link_msg
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_wr = 1'b0;
    link_msg = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end

  // ---------------------------------------------------------------
  // Single write, bus inverted once released
  // ---------------------------------------------------------------
  task automatic write_reg(input logic [15:0] addr, input logic [15:0] data);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    link_msg = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    link_msg = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask

  // Password, gap in cycles, then mode code
  task automatic send_cmd(input logic [15:0] pw, input logic [15:0] code, input int gap);
    write_reg(REG_PASSWORD, pw);
    repeat (gap) @(posedge clk);
    write_reg(REG_MODE_CODE, code);
  endtask
endmodule

// ==== sim/tb_operating_mode_sequencer.sv ====
// Self-checking bench of the operating-mode sequencer
// Assumes shortened timing parameters and the master model beside the dut
module tb_operating_mode_sequencer;
  import oms_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int WIN = 20;
  localparam int SIL = 40;
  localparam int HOLD = 10;
  localparam int LAMP = 8;
  localparam int MINU = 20;
  localparam logic [15:0] PW = 16'h1234;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  oms_din_type din = '0;
  oms_panel_type panel = '0;
  oms_cfg_type cfg = '0;
  logic auto_start_request = 1'b0;
  logic sched_test_window = 1'b0;
  logic sched_remote_window = 1'b0;
  logic reg_wr, link_msg;
  logic [15:0] reg_addr, reg_wdata, evt_code, last_evt;
  oms_dout_type dout;
  oms_stat_type stat;
  logic auto_lamp, gb_open, gb_close, evt_valid;
  int miscompares = 0;
  int compares = 0;
  int n;
  logic [15:0] codes [4] = '{CODE_MAN, CODE_AUTO, CODE_OFF, CODE_AUTO};
  oms_mode_type modes [4] = '{MODE_MAN, MODE_AUTO, MODE_OFF, MODE_AUTO};
  logic [15:0] evts [4] = '{EVT_MAN, EVT_AUTOMATIC, EVT_OFF, EVT_AUTOMATIC};

  always #20 clk = ~clk;

  oms_sequencer #(.CMD_WINDOW(WIN), .LINK_SILENCE(SIL), .BUTTON_HOLD(HOLD),
    .LAMP_HALF(LAMP), .MINUTE(MINU)) dut (.clk(clk), .rst_n(rst_n), .din(din),
    .panel(panel), .cfg(cfg), .auto_start_request(auto_start_request),
    .sched_test_window(sched_test_window), .sched_remote_window(sched_remote_window),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .link_msg(link_msg),
    .dout(dout), .stat(stat), .auto_lamp(auto_lamp),
    .generator_breaker_force_open(gb_open), .generator_breaker_force_close(gb_close),
    .evt_valid(evt_valid), .evt_code(evt_code));

  oms_master_model master (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .link_msg(link_msg));

  always @(posedge clk) begin
    if (evt_valid === 1'b1) begin
      last_evt <= evt_code;
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_mode(input oms_mode_type m);
    oms_stat_type s;
    step(4);
    s = {m == MODE_OFF, m == MODE_MAN, m == MODE_AUTO, m == MODE_TEST, m == MODE_REMOTE};
    check_val(16'(stat), 16'(s), "status flags");
    check_val(16'(dout), 16'({s, s[3] | s[2], s[2] | s[1] | s[0]}), "mode outputs");
  endtask

  task automatic final_report;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    cfg.password = PW;
    cfg.log_options = 16'h0001;
    step(5);
    rst_n = 1'b1;
    check_mode(MODE_OFF);
    for (int i = 0; i < 4; i++) begin
      master.send_cmd(PW, codes[i], 0);
      check_mode(modes[i]);
      check_val(last_evt, evts[i], "event code");
    end
    master.send_cmd(16'h4321, CODE_MAN, 0);
    check_mode(MODE_AUTO);
    master.send_cmd(PW, CODE_MAN, WIN + 5);
    check_mode(MODE_AUTO);
    master.send_cmd(PW, 16'h0007, 0);
    check_mode(MODE_AUTO);
    master.write_reg(REG_MODE_CODE, CODE_MAN);
    check_mode(MODE_AUTO);
    din.force_auto_input = 1'b1;
    master.send_cmd(PW, CODE_MAN, 0);
    check_mode(MODE_AUTO);
    din.force_off_input = 1'b1;
    din.force_manual_input = 1'b1;
    check_mode(MODE_OFF);
    din.force_off_input = 1'b0;
    check_mode(MODE_MAN);
    din.force_manual_input = 1'b0;
    check_mode(MODE_AUTO);
    din.force_auto_input = 1'b0;
    din.password_bypass_input = 1'b1;
    master.write_reg(REG_MODE_CODE, CODE_MAN);
    check_mode(MODE_MAN);
    din.password_bypass_input = 1'b0;
    master.send_cmd(PW, CODE_TEST, 0);
    check_mode(MODE_MAN);
    master.send_cmd(PW, CODE_AUTO, 0);
    auto_start_request = 1'b1;
    master.send_cmd(PW, CODE_TEST, 0);
    check_mode(MODE_AUTO);
    auto_start_request = 1'b0;
    check_mode(MODE_AUTO);
    master.send_cmd(PW, CODE_TEST, 0);
    check_mode(MODE_TEST);
    n = 0;
    for (int i = 0; i < 2 * LAMP; i++) begin
      step(1);
      n += (auto_lamp === 1'b1);
    end
    check_val(16'(n), 16'(LAMP), "lamp on cycles");
    master.send_cmd(PW, CODE_BACK_AUTO, 0);
    check_mode(MODE_AUTO);
    master.send_cmd(PW, CODE_TEST, 0);
    step(SIL + 8);
    check_mode(MODE_AUTO);
    for (int i = 0; i < 3; i++) begin
      panel.start_button = 1'b1;
      step(3);
      panel.start_button = 1'b0;
      check_mode(i == 0 ? MODE_TEST : MODE_AUTO);
      cfg.button_options = (i == 1) ? 16'h0002 : 16'h0000;
    end
    din.test_level_input = 1'b1;
    check_mode(MODE_TEST);
    din.test_level_input = 1'b0;
    check_mode(MODE_AUTO);
    cfg.test_minutes = 16'h0001;
    din.pulse_test_no_load_input = 1'b1;
    check_mode(MODE_TEST);
    check_val(16'(gb_open), 16'h0001, "breaker held open");
    din.pulse_test_no_load_input = 1'b0;
    step(MINU + 6);
    check_mode(MODE_AUTO);
    din.pulse_test_with_load_input = 1'b1;
    check_mode(MODE_TEST);
    check_val(16'(gb_close), 16'h0001, "breaker closed");
    check_val(16'(gb_open), 16'h0000, "breaker not held open");
    din.pulse_test_with_load_input = 1'b0;
    step(2);
    din.pulse_test_with_load_input = 1'b1;
    check_mode(MODE_AUTO);
    din.pulse_test_with_load_input = 1'b0;
    cfg.test_minutes = 16'h0000;
    step(2);
    din.pulse_test_no_load_input = 1'b1;
    check_mode(MODE_AUTO);
    din.pulse_test_no_load_input = 1'b0;
    cfg.remote_enable_used = 1'b1;
    master.send_cmd(PW, CODE_REMOTE, 0);
    check_mode(MODE_AUTO);
    din.remote_start_enable_input = 1'b1;
    master.send_cmd(PW, CODE_REMOTE, 0);
    check_mode(MODE_REMOTE);
    step(SIL + 8);
    check_mode(MODE_REMOTE);
    master.send_cmd(PW, CODE_BACK_AUTO, 0);
    check_mode(MODE_AUTO);
    din.test_level_input = 1'b1;
    check_mode(MODE_TEST);
    din.remote_start_request_input = 1'b1;
    check_mode(MODE_REMOTE);
    din.test_level_input = 1'b0;
    check_mode(MODE_REMOTE);
    din.remote_start_request_input = 1'b0;
    check_mode(MODE_AUTO);
    sched_test_window = 1'b1;
    check_mode(MODE_TEST);
    sched_test_window = 1'b0;
    check_mode(MODE_AUTO);
    sched_remote_window = 1'b1;
    check_mode(MODE_REMOTE);
    sched_remote_window = 1'b0;
    check_mode(MODE_AUTO);
    panel.mode_down_button = 1'b1;
    step(3);
    panel.mode_down_button = 1'b0;
    check_mode(MODE_AUTO);
    panel.mode_down_button = 1'b1;
    step(HOLD + 4);
    panel.mode_down_button = 1'b0;
    check_mode(MODE_MAN);
    check_val(last_evt, EVT_MAN, "event code");
    cfg.off_only_forcing = 1'b1;
    cfg.log_options = 16'h0000;
    din.force_off_input = 1'b1;
    check_mode(MODE_OFF);
    check_val(last_evt, EVT_MAN, "event while logging off");
    din.force_off_input = 1'b0;
    check_mode(MODE_MAN);
    final_report();
  end
endmodule

// ==== verilog/oms_pkg.sv ====
// Constants and types of the operating-mode sequencer
// Assumes one 25 MHz clock and a host that presents holding-register writes as strobes
// Function
// R1: Remote mode commands are ignored while any forcing input is active.
// R2: Password to register 101, then mode code to 102, within 5 s.
// R3: Codes 1, 2, 3 request OFF, MAN and AUTO.
// R4: Code 12 requests TEST, 13 REMOTE START, 21 returns to AUTO.
// R5: Password check is optional and skipped while the bypass input is active.
// R6: TEST is entered only from AUTO with no automatic start request.
// R7: AUTO lamp flashes with equal on and off times in TEST.
// R8: Start button toggles AUTO and TEST unless option bit 1 disables it.
// R9: Weekly schedule enters TEST at set moments and returns to AUTO after.
// R10: Serial TEST ends on opposite command or 60 s without messages.
// R11: Level test input holds TEST while active, AUTO on release.
// R12: No-load pulse edge starts timed TEST with generator breaker held open.
// R13: With-load pulse edge starts timed TEST with generator breaker closed.
// R14: A second pulse edge during a pulse test stops it at once.
// R15: Zero test duration prevents pulse-triggered tests.
// R16: REMOTE START only from AUTO or TEST, and only with enable input if used.
// R17: Remote-start request input holds REMOTE START; release reverts to AUTO.
// R18: Remote window end after start is same day, before is next, equal full day.
// R19: Command-entered REMOTE START survives link loss; only opposite command ends it.
// R20: With logging bit 0 set, each mode change logs 1001, 1002 or 1003.
// R21: Mode outputs are each active exactly in their own mode.
// R22: Not-off output in AUTO or MAN; automatic output in AUTO, TEST, REMOTE.
// R23: Five internal status flags expose the five modes.
// R24: Forcing OFF beats forcing MAN, which beats forcing AUTO.
// R25: Mode buttons need half a second hold and are ignored while forcing.
// R26: With only the OFF forcing input used, release restores the earlier mode.
// R27: Missing, late, wrong-password or undefined-code sequences leave the mode unchanged.
// R28: TEST or REMOTE START requests whose conditions fail are ignored, not queued.
package oms_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int CMD_WINDOW_S = 5;
  localparam int LINK_SILENCE_S = 60;
  localparam int BUTTON_HOLD_MS = 500;
  localparam int LAMP_HALF_MS = 500;
  localparam int CMD_WINDOW_CYC = CMD_WINDOW_S * CLK_HZ;
  localparam int LINK_SILENCE_CYC = LINK_SILENCE_S * CLK_HZ;
  localparam int BUTTON_HOLD_CYC = (BUTTON_HOLD_MS * (CLK_HZ / 1000));
  localparam int LAMP_HALF_CYC = (LAMP_HALF_MS * (CLK_HZ / 1000));
  localparam int MIN_CYC = 60 * CLK_HZ;

  localparam logic [15:0] REG_PASSWORD = 16'h0065;
  localparam logic [15:0] REG_MODE_CODE = 16'h0066;

  localparam logic [15:0] CODE_OFF = 16'h0001;
  localparam logic [15:0] CODE_MAN = 16'h0002;
  localparam logic [15:0] CODE_AUTO = 16'h0003;
  localparam logic [15:0] CODE_TEST = 16'h000C;
  localparam logic [15:0] CODE_REMOTE = 16'h000D;
  localparam logic [15:0] CODE_BACK_AUTO = 16'h0015;

  localparam logic [15:0] EVT_OFF = 16'h03E9;
  localparam logic [15:0] EVT_MAN = 16'h03EA;
  localparam logic [15:0] EVT_AUTOMATIC = 16'h03EB;

  localparam int BTN_TOGGLE_OFF_BIT = 1;
  localparam int LOG_ENABLE_BIT = 0;

  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_MAN,
    MODE_AUTO,
    MODE_TEST,
    MODE_REMOTE
  } oms_mode_type;

  // Origin of a running TEST
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_BUTTON,
    SRC_SCHED,
    SRC_SERIAL,
    SRC_LEVEL,
    SRC_PULSE
  } oms_src_type;

  typedef struct packed {
    logic force_off_input;
    logic force_manual_input;
    logic force_auto_input;
    logic password_bypass_input;
    logic test_level_input;
    logic pulse_test_no_load_input;
    logic pulse_test_with_load_input;
    logic remote_start_enable_input;
    logic remote_start_request_input;
  } oms_din_type;

  typedef struct packed {
    logic mode_up_button;
    logic mode_down_button;
    logic start_button;
  } oms_panel_type;

  typedef struct packed {
    logic off_only_forcing;
    logic remote_enable_used;
    logic [15:0] password;
    logic [15:0] button_options;
    logic [15:0] log_options;
    logic [15:0] test_minutes;
  } oms_cfg_type;

  typedef struct packed {
    logic out_off_mode;
    logic out_manual_mode;
    logic out_auto_mode;
    logic out_test_mode;
    logic out_remote_mode;
    logic out_not_off;
    logic out_any_automatic;
  } oms_dout_type;

  typedef struct packed {
    logic stat_off;
    logic stat_manual;
    logic stat_automatic;
    logic stat_test;
    logic stat_remote;
  } oms_stat_type;

endpackage

// ==== verilog/oms_sequencer.sv ====
// Operating-mode state machine with remote command decoder and test timers
// Assumes synchronous inputs, schedule windows decoded by a clock/calendar block
module oms_sequencer
  import oms_pkg::*;
#(
  parameter int CMD_WINDOW = CMD_WINDOW_CYC,
  parameter int LINK_SILENCE = LINK_SILENCE_CYC,
  parameter int BUTTON_HOLD = BUTTON_HOLD_CYC,
  parameter int LAMP_HALF = LAMP_HALF_CYC,
  parameter int MINUTE = MIN_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire oms_din_type din,
  input wire oms_panel_type panel,
  input wire oms_cfg_type cfg,
  input wire logic auto_start_request,
  input wire logic sched_test_window,
  input wire logic sched_remote_window,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic link_msg,
  output oms_dout_type dout,
  output oms_stat_type stat,
  output logic auto_lamp,
  output logic generator_breaker_force_open,
  output logic generator_breaker_force_close,
  output logic evt_valid,
  output logic [15:0] evt_code
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  oms_mode_type mode_q, mode_d, saved_q;
  oms_src_type src_q;
  logic [31:0] cmd_cnt_q, link_cnt_q, hold_cnt_q, lamp_cnt_q, test_cnt_q;
  logic pw_ok_q, lamp_q, start_q, pulse_nl_q, pulse_wl_q, level_q, sched_t_q;
  logic cmd_remote_q, fo_q, load_q;
  oms_dout_type dout_q;
  oms_stat_type stat_q;
  logic evt_valid_q;
  logic [15:0] evt_code_q;
  logic gb_open_q, gb_close_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire forcing = din.force_off_input | din.force_manual_input | din.force_auto_input;
  wire wr_pw = reg_wr && reg_addr == REG_PASSWORD;
  wire wr_code = reg_wr && reg_addr == REG_MODE_CODE;
  wire pw_match = din.password_bypass_input || reg_wdata == cfg.password; // R5
  wire code_take = wr_code && !forcing && (pw_ok_q || din.password_bypass_input); // R1 R2 R27
  wire c_off = code_take && reg_wdata == CODE_OFF; // R3
  wire c_man = code_take && reg_wdata == CODE_MAN;
  wire c_auto = code_take && reg_wdata == CODE_AUTO;
  wire c_test = code_take && reg_wdata == CODE_TEST; // R4
  wire c_rem = code_take && reg_wdata == CODE_REMOTE;
  wire c_back = code_take && reg_wdata == CODE_BACK_AUTO;
  wire start_edge = panel.start_button && !start_q;
  wire nl_edge = din.pulse_test_no_load_input && !pulse_nl_q;
  wire wl_edge = din.pulse_test_with_load_input && !pulse_wl_q;
  wire pulse_edge = nl_edge | wl_edge;
  wire level_rise = din.test_level_input && !level_q;
  wire sched_rise = sched_test_window && !sched_t_q;
  wire can_test = mode_q == MODE_AUTO && !auto_start_request; // R6 R28
  wire rem_en = !cfg.remote_enable_used || din.remote_start_enable_input; // R16
  wire can_rem = (mode_q == MODE_AUTO || mode_q == MODE_TEST) && rem_en;
  wire btn_toggle = start_edge && !cfg.button_options[BTN_TOGGLE_OFF_BIT] && !forcing; // R8
  wire hold_done = hold_cnt_q == BUTTON_HOLD - 1;
  wire btn_held = panel.mode_up_button ^ panel.mode_down_button;
  wire test_time_up = test_cnt_q == 32'h0000_0001;
  wire rem_hold = din.remote_start_request_input || sched_remote_window || cmd_remote_q; // R18
  wire test_entry = mode_d == MODE_TEST && mode_q != MODE_TEST;
  wire pulse_start = test_entry && !c_test && !level_rise && !sched_rise && !btn_toggle;

  function automatic oms_mode_type step_mode(input oms_mode_type m, input logic up);
    case (m)
      MODE_OFF: step_mode = up ? MODE_MAN : MODE_OFF;
      MODE_MAN: step_mode = up ? MODE_AUTO : MODE_OFF;
      default: step_mode = up ? MODE_AUTO : MODE_MAN;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next mode
  // ----------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    if (din.force_off_input) begin // R24
      mode_d = MODE_OFF;
    end else if (din.force_manual_input) begin
      mode_d = MODE_MAN;
    end else if (din.force_auto_input) begin
      mode_d = MODE_AUTO;
    end else if (fo_q && cfg.off_only_forcing) begin // R26
      mode_d = saved_q;
    end else if (c_off) begin
      mode_d = MODE_OFF;
    end else if (c_man) begin
      mode_d = MODE_MAN;
    end else if (c_auto) begin
      mode_d = MODE_AUTO;
    end else if (hold_done && btn_held) begin // R25
      mode_d = step_mode(mode_q, panel.mode_up_button);
    end else begin
      case (mode_q)
        MODE_AUTO: begin
          if ((din.remote_start_request_input || sched_remote_window || c_rem) && can_rem) begin
            mode_d = MODE_REMOTE; // R16 R17
          end else if (can_test && (btn_toggle || c_test || level_rise || sched_rise)) begin
            mode_d = MODE_TEST; // R9 R11
          end else if (can_test && pulse_edge && cfg.test_minutes != 16'h0000) begin
            mode_d = MODE_TEST; // R12 R13 R15
          end
        end
        MODE_TEST: begin
          if ((din.remote_start_request_input || sched_remote_window || c_rem) && can_rem) begin
            mode_d = MODE_REMOTE;
          end else if (auto_start_request || c_back) begin
            mode_d = MODE_AUTO; // R10
          end else begin
            case (src_q)
              SRC_BUTTON: if (btn_toggle) mode_d = MODE_AUTO; // R8
              SRC_SCHED: if (!sched_test_window) mode_d = MODE_AUTO; // R9
              SRC_SERIAL: if (link_cnt_q >= LINK_SILENCE - 1) mode_d = MODE_AUTO; // R10
              SRC_LEVEL: if (!din.test_level_input) mode_d = MODE_AUTO; // R11
              SRC_PULSE: if (pulse_edge || test_time_up) mode_d = MODE_AUTO; // R14
              default: mode_d = MODE_TEST;
            endcase
          end
        end
        MODE_REMOTE: begin
          if (c_back || !rem_hold) begin
            mode_d = MODE_AUTO; // R17 R19
          end
        end
        default: mode_d = mode_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= MODE_OFF;
      saved_q <= MODE_OFF;
      src_q <= SRC_NONE;
      cmd_cnt_q <= 32'h0000_0000;
      link_cnt_q <= 32'h0000_0000;
      hold_cnt_q <= 32'h0000_0000;
      lamp_cnt_q <= 32'h0000_0000;
      test_cnt_q <= 32'h0000_0000;
      pw_ok_q <= 1'b0;
      lamp_q <= 1'b0;
      start_q <= 1'b0;
      pulse_nl_q <= 1'b0;
      pulse_wl_q <= 1'b0;
      level_q <= 1'b0;
      sched_t_q <= 1'b0;
      cmd_remote_q <= 1'b0;
      fo_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      start_q <= panel.start_button;
      pulse_nl_q <= din.pulse_test_no_load_input;
      pulse_wl_q <= din.pulse_test_with_load_input;
      level_q <= din.test_level_input;
      sched_t_q <= sched_test_window;
      fo_q <= din.force_off_input;
      if (din.force_off_input && !fo_q) begin
        saved_q <= mode_q; // R26
      end
      // Password window
      if (wr_pw && pw_match) begin // R2
        pw_ok_q <= 1'b1;
        cmd_cnt_q <= 32'h0000_0000;
      end else if (wr_code || cmd_cnt_q >= CMD_WINDOW - 1) begin
        pw_ok_q <= 1'b0; // R27
      end else if (pw_ok_q) begin
        cmd_cnt_q <= cmd_cnt_q + 32'h0000_0001;
      end
      link_cnt_q <= (link_msg || reg_wr) ? 32'h0000_0000 : link_cnt_q + 32'h0000_0001;
      hold_cnt_q <= (btn_held && !forcing && hold_cnt_q < BUTTON_HOLD) ? // R25
                    hold_cnt_q + 32'h0000_0001 : (btn_held ? hold_cnt_q : 32'h0000_0000);
      // Test origin and timer
      if (mode_d == MODE_TEST && mode_q != MODE_TEST) begin
        if (c_test) src_q <= SRC_SERIAL;
        else if (level_rise) src_q <= SRC_LEVEL;
        else if (sched_rise) src_q <= SRC_SCHED;
        else if (btn_toggle) src_q <= SRC_BUTTON;
        else src_q <= SRC_PULSE;
        load_q <= wl_edge; // R12 R13
        test_cnt_q <= 32'(cfg.test_minutes) * 32'(MINUTE);
      end else if (test_cnt_q != 32'h0000_0000) begin
        test_cnt_q <= test_cnt_q - 32'h0000_0001;
      end
      if (mode_d != MODE_TEST) src_q <= SRC_NONE;
      if (c_rem && can_rem) cmd_remote_q <= 1'b1;
      else if (mode_d != MODE_REMOTE) cmd_remote_q <= 1'b0;
      // Lamp flash
      if (mode_q == MODE_TEST && lamp_cnt_q < LAMP_HALF - 1) begin
        lamp_cnt_q <= lamp_cnt_q + 32'h0000_0001;
      end else begin
        lamp_cnt_q <= 32'h0000_0000;
        lamp_q <= (mode_q == MODE_TEST) ? !lamp_q : 1'b0; // R7
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout_q <= '0;
      stat_q <= '0;
      evt_valid_q <= 1'b0;
      evt_code_q <= 16'h0000;
      gb_open_q <= 1'b0;
      gb_close_q <= 1'b0;
    end else begin
      gb_open_q <= mode_d == MODE_TEST &&
                   (pulse_start ? !wl_edge : (src_q == SRC_PULSE && !load_q)); // R12
      gb_close_q <= mode_d == MODE_TEST &&
                    (pulse_start ? wl_edge : (src_q == SRC_PULSE && load_q)); // R13
      dout_q.out_off_mode <= mode_d == MODE_OFF; // R21
      dout_q.out_manual_mode <= mode_d == MODE_MAN;
      dout_q.out_auto_mode <= mode_d == MODE_AUTO;
      dout_q.out_test_mode <= mode_d == MODE_TEST;
      dout_q.out_remote_mode <= mode_d == MODE_REMOTE;
      dout_q.out_not_off <= mode_d == MODE_AUTO || mode_d == MODE_MAN; // R22
      dout_q.out_any_automatic <= mode_d == MODE_AUTO || mode_d == MODE_TEST ||
                                  mode_d == MODE_REMOTE;
      stat_q <= {mode_d == MODE_OFF, mode_d == MODE_MAN, mode_d == MODE_AUTO,
                 mode_d == MODE_TEST, mode_d == MODE_REMOTE}; // R23
      evt_valid_q <= mode_d != mode_q && cfg.log_options[LOG_ENABLE_BIT]; // R20
      evt_code_q <= mode_d == MODE_OFF ? EVT_OFF : (mode_d == MODE_MAN ? EVT_MAN : EVT_AUTOMATIC);
    end
  end

  assign dout = dout_q;
  assign stat = stat_q;
  assign auto_lamp = lamp_q;
  assign evt_valid = evt_valid_q;
  assign evt_code = evt_code_q;
  assign generator_breaker_force_open = gb_open_q;
  assign generator_breaker_force_close = gb_close_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_force_off;
    @(posedge clk) disable iff (!rst_n) din.force_off_input |=> mode_q == MODE_OFF;
  endproperty
  a_force_off: assert property (p_force_off) else $error("force off ignored"); // R24
  property p_no_remote_forcing;
    @(posedge clk) disable iff (!rst_n)
      (wr_code && forcing) |-> mode_d == (din.force_off_input ? MODE_OFF :
                                          (din.force_manual_input ? MODE_MAN : MODE_AUTO));
  endproperty
  a_no_remote_forcing: assert property (p_no_remote_forcing) else $error("cmd under forcing"); // R1
  property p_test_entry;
    @(posedge clk) disable iff (!rst_n)
      (mode_q != MODE_TEST && mode_d == MODE_TEST) |-> mode_q == MODE_AUTO && !auto_start_request;
  endproperty
  a_test_entry: assert property (p_test_entry) else $error("test entered from non auto"); // R6
  property p_out_test;
    @(posedge clk) disable iff (!rst_n) ##1 dout.out_test_mode == (mode_q == MODE_TEST);
  endproperty
  a_out_test: assert property (p_out_test) else $error("test output wrong"); // R21
  property p_rem_entry;
    @(posedge clk) disable iff (!rst_n) (mode_q != MODE_REMOTE && mode_d == MODE_REMOTE) |-> rem_en;
  endproperty
  a_rem_entry: assert property (p_rem_entry) else $error("remote without enable"); // R16
  property p_evt;
    @(posedge clk) disable iff (!rst_n)
      (mode_d != mode_q && cfg.log_options[LOG_ENABLE_BIT]) |=> evt_valid;
  endproperty
  a_evt: assert property (p_evt) else $error("mode change not logged"); // R20
  property p_lamp_off;
    @(posedge clk) disable iff (!rst_n) (mode_q != MODE_TEST) [*2] |-> !auto_lamp;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp flashing outside test"); // R7
  property p_zero_dur;
    @(posedge clk) disable iff (!rst_n)
      (mode_q == MODE_AUTO && pulse_edge && cfg.test_minutes == 16'h0000 && !level_rise &&
       !sched_rise && !btn_toggle && !c_test) |-> mode_d != MODE_TEST;
  endproperty
  a_zero_dur: assert property (p_zero_dur) else $error("pulse test with zero time"); // R15

endmodule
